// ==== hdl/scmc_defs.svh ====
// Offsets, field positions, reset values and widths of the sync and clamp mode control
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH

`define SCMC_ADDR_W 8
`define SCMC_DATA_W 8
`define SCMC_ADDR_MODE 8'h0E
`define SCMC_ADDR_CLAMP 8'h0F
`define SCMC_ADDR_STATUS 8'h14

`define SCMC_RST_MODE 8'h40
`define SCMC_RST_CLAMP 8'h4E

`define SCMC_BIT_HSYNC_DET 7
`define SCMC_BIT_HS_SRC 6
`define SCMC_BIT_HPOL_DET 5
`define SCMC_BIT_VSYNC_DET 4
`define SCMC_BIT_GREEN_DET 1

`define SCMC_PIN_COUNT 6
`define SCMC_PCNT_W 12
`define SCMC_PCNT_MAX 12'hFFF
`define SCMC_CNT_W 8

`endif

// ==== hdl/scmc_pkg.sv ====
// Types shared by the sync and clamp mode control files
`default_nettype none
package scmc_pkg;

  // Field order follows bits 7 down to 0 of the sync mode register
  typedef struct packed {
    logic pol_override;
    logic hsync_input_polarity_bit;
    logic hsync_out_pol;
    logic hs_src_override;
    logic hs_src_select;
    logic vsync_out_keep;
    logic avs_override;
    logic avs_select;
  } scmc_mode_type;

  // Field order follows bits 7 down to 0 of the clamp and coast register
  typedef struct packed {
    logic clamp_external;
    logic clamp_active_low;
    logic coast_from_vsync;
    logic [4:0] spare;
  } scmc_clamp_type;

  typedef struct packed {
    logic hsync;
    logic green_embedded_sync;
    logic vsync;
    logic sep_vsync;
    logic clamp;
    logic coast;
  } scmc_pins_type;

  typedef enum logic [1:0] {
    CL_IDLE,
    CL_PLACE,
    CL_ACTIVE
  } scmc_clamp_state_type;

endpackage
`default_nettype wire

// ==== hdl/scmc_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter for the sync and clamp pins
`timescale 1ns/100ps
`default_nettype none
`include "scmc_defs.svh"

module scmc_pin_sync
  import scmc_pkg::*;
(
  input wire logic sys_clk_i,        // System clock
  input wire logic rst_n_i,          // Async reset, active low
  input wire scmc_pins_type pins_i,  // Raw pins
  output scmc_pins_type pins_o       // Filtered, synchronised pins
);

  logic [`SCMC_PIN_COUNT-1:0] raw;
  logic [`SCMC_PIN_COUNT-1:0] clean;

  assign raw = pins_i;
  assign pins_o = clean;

  genvar gi;
  generate
    for (gi = 0; gi < `SCMC_PIN_COUNT; gi++)
    begin : g_bit
      logic [2:0] sh_ff;
      logic [2:0] nxt_sh;
      logic out_ff;
      logic nxt_out;

      // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2
      always_comb
      begin
        nxt_sh = {sh_ff[1:0], raw[gi]};
        nxt_out = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : out_ff;
      end

      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          sh_ff <= 3'h0;
          out_ff <= 1'b0;
        end
        else
        begin
          sh_ff <= nxt_sh;
          out_ff <= nxt_out;
        end
      end

      assign clean[gi] = out_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== hdl/scmc_hpol_detect.sv ====
// Hsync polarity detector: the shorter of the high and low phases is the pulse
`timescale 1ns/100ps
`default_nettype none
`include "scmc_defs.svh"

module scmc_hpol_detect
  import scmc_pkg::*;
(
  input wire logic sys_clk_i,  // System clock
  input wire logic rst_n_i,    // Async reset, active low
  input wire logic hsync_i,    // Synchronised selected hsync
  output logic positive_o      // 1 when the pulse is high-going
);

  logic prev_ff;
  logic nxt_prev;
  logic [`SCMC_PCNT_W-1:0] run_ff;
  logic [`SCMC_PCNT_W-1:0] nxt_run;
  logic [`SCMC_PCNT_W-1:0] high_len_ff;
  logic [`SCMC_PCNT_W-1:0] nxt_high_len;
  logic [`SCMC_PCNT_W-1:0] low_len_ff;
  logic [`SCMC_PCNT_W-1:0] nxt_low_len;
  logic pos_ff;
  logic nxt_pos;

  // Saturating run counter so a stuck line keeps the last verdict
  always_comb
  begin
    nxt_prev = hsync_i;
    nxt_high_len = high_len_ff;
    nxt_low_len = low_len_ff;
    nxt_run = (run_ff == `SCMC_PCNT_MAX) ? run_ff : run_ff + 1'b1;
    if (hsync_i != prev_ff)
    begin
      nxt_run = '0;
      if (prev_ff)
        nxt_high_len = run_ff;
      else
        nxt_low_len = run_ff;
    end
    nxt_pos = pos_ff;
    if (high_len_ff != low_len_ff)
      nxt_pos = (high_len_ff < low_len_ff);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_ff <= 1'b0;
      run_ff <= '0;
      high_len_ff <= '0;
      low_len_ff <= '0;
      pos_ff <= 1'b1;
    end
    else
    begin
      prev_ff <= nxt_prev;
      run_ff <= nxt_run;
      high_len_ff <= nxt_high_len;
      low_len_ff <= nxt_low_len;
      pos_ff <= nxt_pos;
    end
  end

  assign positive_o = pos_ff;

endmodule
`default_nettype wire

// ==== hdl/scmc_top.sv ====
// Sync polarity, sync source, clamp source and coast source mode control
`timescale 1ns/100ps
`default_nettype none
`include "scmc_defs.svh"

module scmc_top
  import scmc_pkg::*;
(
  input wire logic sys_clk_i,                      // System clock, 40 MHz
  input wire logic rst_n_i,                        // Async reset, active low
  input wire logic reg_wr_i,                       // Register write strobe
  input wire logic reg_rd_i,                       // Register read strobe
  input wire logic [`SCMC_ADDR_W-1:0] reg_addr_i,  // Register offset
  input wire logic [`SCMC_DATA_W-1:0] reg_wdata_i, // Write data
  output logic [`SCMC_DATA_W-1:0] reg_rdata_o,     // Read data
  output logic reg_rvalid_o,                       // Read data valid pulse
  input wire scmc_pins_type pins_i,                // Raw sync, clamp and coast pins
  input wire logic hsync_activity_i,               // Hsync pin activity seen
  input wire logic green_activity_i,               // Green embedded sync activity seen
  input wire logic vsync_activity_i,               // Vsync pin activity seen
  input wire logic [`SCMC_CNT_W-1:0] clamp_place_i, // Internal clamp start delay
  input wire logic [`SCMC_CNT_W-1:0] clamp_dur_i,   // Internal clamp length
  output logic hsync_o,                            // Hsync output
  output logic green_sync_o,                       // Green embedded sync output
  output logic vsync_o,                            // Vsync output
  output logic pll_hsync_o,                        // Active-high hsync to the PLL
  output logic hsync_lead_o,                       // Leading edge pulse of active hsync
  output logic clamp_o,                            // Clamp all three channels
  output logic coast_o,                            // Selected coast source
  output logic active_hsync_source_o,              // 0 pin, 1 green embedded sync
  output logic active_vsync_source_o,              // 0 pin, 1 sync separator
  output logic hsync_polarity_o                    // Polarity in use, 1 active high
);

  scmc_mode_type mode_ff;
  scmc_mode_type nxt_mode;
  scmc_clamp_type clampc_ff;
  scmc_clamp_type nxt_clampc;
  logic [`SCMC_DATA_W-1:0] rdata_ff;
  logic [`SCMC_DATA_W-1:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  scmc_pins_type pins_s;
  logic detected_pos;

  logic hs_src;
  logic avs;
  logic pol;
  logic hs_raw;
  logic hs_norm;
  logic green_norm;
  logic vs_sel;
  logic ext_clamp;
  logic [`SCMC_DATA_W-1:0] status;

  logic prev_ff;
  logic nxt_prev;
  scmc_clamp_state_type cst_ff;
  scmc_clamp_state_type nxt_cst;
  logic [`SCMC_CNT_W-1:0] ccnt_ff;
  logic [`SCMC_CNT_W-1:0] nxt_ccnt;

  logic hsync_ff;
  logic nxt_hsync;
  logic green_ff;
  logic nxt_green;
  logic vsync_ff;
  logic nxt_vsync;
  logic pll_ff;
  logic nxt_pll;
  logic lead_ff;
  logic nxt_lead;
  logic clamp_ff;
  logic nxt_clamp;
  logic coast_ff;
  logic nxt_coast;
  logic lead;

  scmc_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pins_i),
    .pins_o(pins_s)
  );

  // Detector watches the selected source before any polarity is applied
  scmc_hpol_detect u_hpol (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .hsync_i(hs_raw),
    .positive_o(detected_pos)
  );

  // Source and polarity selection
  always_comb
  begin
    if (mode_ff.hs_src_override)
      hs_src = mode_ff.hs_src_select;
    else if (hsync_activity_i && !green_activity_i)
      hs_src = 1'b0;
    else if (!hsync_activity_i && green_activity_i)
      hs_src = 1'b1;
    else
      hs_src = mode_ff.hs_src_select;
    hs_raw = hs_src ? pins_s.green_embedded_sync : pins_s.hsync;
    pol = mode_ff.pol_override ? mode_ff.hsync_input_polarity_bit : detected_pos;
    hs_norm = pol ? hs_raw : ~hs_raw;
    green_norm = pol ? pins_s.green_embedded_sync : ~pins_s.green_embedded_sync;
    // Without override, take the pin while it toggles, else fall back to the separator
    if (mode_ff.avs_override)
      avs = mode_ff.avs_select;
    else
      avs = ~vsync_activity_i;
    vs_sel = avs ? pins_s.sep_vsync : pins_s.vsync;
    ext_clamp = clampc_ff.clamp_active_low ? ~pins_s.clamp : pins_s.clamp;
    lead = hs_norm & ~prev_ff;
  end

  // Register write and read
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_clampc = clampc_ff;
    if (reg_wr_i && reg_addr_i == `SCMC_ADDR_MODE)
      nxt_mode = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == `SCMC_ADDR_CLAMP)
      nxt_clampc = reg_wdata_i;
    status = '0;
    status[`SCMC_BIT_HSYNC_DET] = hsync_activity_i;
    status[`SCMC_BIT_HS_SRC] = hs_src;
    status[`SCMC_BIT_HPOL_DET] = detected_pos;
    status[`SCMC_BIT_VSYNC_DET] = vsync_activity_i;
    status[`SCMC_BIT_GREEN_DET] = green_activity_i;
    nxt_rvalid = reg_rd_i;
    nxt_rdata = rdata_ff;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `SCMC_ADDR_MODE: nxt_rdata = mode_ff;
        `SCMC_ADDR_CLAMP: nxt_rdata = clampc_ff;
        `SCMC_ADDR_STATUS: nxt_rdata = status;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_ff <= `SCMC_RST_MODE;
      clampc_ff <= `SCMC_RST_CLAMP;
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      clampc_ff <= nxt_clampc;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Internal clamp: wait placement cycles after the leading edge, then hold duration cycles.
  // A new leading edge restarts the sequence, so a wrong polarity only shifts the clamp.
  always_comb
  begin
    nxt_prev = hs_norm;
    nxt_cst = cst_ff;
    nxt_ccnt = ccnt_ff;
    if (lead)
    begin
      nxt_cst = CL_PLACE;
      nxt_ccnt = (clamp_place_i == '0) ? 8'h01 : clamp_place_i;
    end
    else
    begin
      unique case (cst_ff)
        CL_IDLE:
          nxt_ccnt = ccnt_ff;
        CL_PLACE:
          if (ccnt_ff <= 8'h01)
          begin
            nxt_cst = (clamp_dur_i == '0) ? CL_IDLE : CL_ACTIVE;
            nxt_ccnt = clamp_dur_i;
          end
          else
            nxt_ccnt = ccnt_ff - 1'b1;
        CL_ACTIVE:
          if (ccnt_ff <= 8'h01)
          begin
            nxt_cst = CL_IDLE;
            nxt_ccnt = '0;
          end
          else
            nxt_ccnt = ccnt_ff - 1'b1;
        default:
        begin
          nxt_cst = CL_IDLE;
          nxt_ccnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_ff <= 1'b0;
      cst_ff <= CL_IDLE;
      ccnt_ff <= '0;
    end
    else
    begin
      prev_ff <= nxt_prev;
      cst_ff <= nxt_cst;
      ccnt_ff <= nxt_ccnt;
    end
  end

  // Output stage, all registered so downstream sees clean levels
  always_comb
  begin
    nxt_hsync = hs_norm ^ mode_ff.hsync_out_pol;
    nxt_green = green_norm ^ mode_ff.hsync_out_pol;
    nxt_vsync = mode_ff.vsync_out_keep ? vs_sel : ~vs_sel;
    nxt_pll = hs_norm;
    nxt_lead = lead;
    if (clampc_ff.clamp_external)
      nxt_clamp = ext_clamp;
    else
      nxt_clamp = (cst_ff == CL_ACTIVE);
    nxt_coast = clampc_ff.coast_from_vsync ? vs_sel : pins_s.coast;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hsync_ff <= 1'b0;
      green_ff <= 1'b0;
      vsync_ff <= 1'b0;
      pll_ff <= 1'b0;
      lead_ff <= 1'b0;
      clamp_ff <= 1'b0;
      coast_ff <= 1'b0;
    end
    else
    begin
      hsync_ff <= nxt_hsync;
      green_ff <= nxt_green;
      vsync_ff <= nxt_vsync;
      pll_ff <= nxt_pll;
      lead_ff <= nxt_lead;
      clamp_ff <= nxt_clamp;
      coast_ff <= nxt_coast;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign hsync_o = hsync_ff;
  assign green_sync_o = green_ff;
  assign vsync_o = vsync_ff;
  assign pll_hsync_o = pll_ff;
  assign hsync_lead_o = lead_ff;
  assign clamp_o = clamp_ff;
  assign coast_o = coast_ff;
  assign active_hsync_source_o = hs_src;
  assign active_vsync_source_o = avs;
  assign hsync_polarity_o = pol;

endmodule
`default_nettype wire

// ==== bench/scmc_chk.sv ====
// Port-level assertions for the sync and clamp mode control
`timescale 1ns/100ps
`default_nettype none
`include "scmc_defs.svh"

module scmc_chk
  import scmc_pkg::*;
(
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [`SCMC_ADDR_W-1:0] reg_addr_i, // Offset
  input wire logic [`SCMC_DATA_W-1:0] reg_wdata_i, // Write data
  input wire logic [`SCMC_DATA_W-1:0] reg_rdata_o, // Read data
  input wire logic reg_rvalid_o, // Read valid
  input wire scmc_pins_type pins_i, // Raw pins
  input wire logic hsync_activity_i, // Hsync activity
  input wire logic green_activity_i, // Green activity
  input wire logic vsync_activity_i, // Vsync activity
  input wire logic hsync_o, // Hsync out
  input wire logic vsync_o, // Vsync out
  input wire logic pll_hsync_o, // Normalised hsync
  input wire logic hsync_lead_o, // Leading edge
  input wire logic clamp_o, // Clamp
  input wire logic coast_o, // Coast
  input wire logic active_hsync_source_o, // Hsync source
  input wire logic active_vsync_source_o, // Vsync source
  input wire logic hsync_polarity_o // Polarity in use
);
  scmc_mode_type mode_ff;
  scmc_mode_type nxt_mode;
  scmc_clamp_type clmp_ff;
  scmc_clamp_type nxt_clmp;
  logic [3:0] last_ff;
  logic [3:0] quiet_ff;
  logic [3:0] nxt_quiet;

  // Shadow of the writable registers; pins quiet count covers synchroniser delay
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_clmp = clmp_ff;
    nxt_quiet = (quiet_ff == 4'hF) ? quiet_ff : quiet_ff + 4'h1;
    if (reg_wr_i && reg_addr_i == `SCMC_ADDR_MODE)
      nxt_mode = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == `SCMC_ADDR_CLAMP)
      nxt_clmp = reg_wdata_i;
    if (reg_wr_i || pins_i[3:0] != last_ff)
      nxt_quiet = 4'h0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_ff <= `SCMC_RST_MODE;
      clmp_ff <= `SCMC_RST_CLAMP;
      last_ff <= 4'h0;
      quiet_ff <= 4'h0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      clmp_ff <= nxt_clmp;
      last_ff <= pins_i[3:0];
      quiet_ff <= nxt_quiet;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_hs_src_ovr;
    mode_ff.hs_src_override |-> active_hsync_source_o == mode_ff.hs_src_select;
  endproperty
  a_hs_src_ovr: assert property (p_hs_src_ovr)
    else $error("hsync source ignores override");
  property p_hs_src_auto;
    !mode_ff.hs_src_override |->
      active_hsync_source_o == ((hsync_activity_i ^ green_activity_i) ? green_activity_i : mode_ff.hs_src_select);
  endproperty
  a_hs_src_auto: assert property (p_hs_src_auto)
    else $error("automatic hsync source wrong");
  property p_avs_ovr;
    mode_ff.avs_override |-> active_vsync_source_o == mode_ff.avs_select;
  endproperty
  a_avs_ovr: assert property (p_avs_ovr)
    else $error("vsync source ignores override");
  property p_hpol_ovr;
    mode_ff.pol_override |-> hsync_polarity_o == mode_ff.hsync_input_polarity_bit;
  endproperty
  a_hpol_ovr: assert property (p_hpol_ovr)
    else $error("polarity ignores user bit");
  property p_hs_out;
    hsync_o == (pll_hsync_o ^ $past(mode_ff.hsync_out_pol));
  endproperty
  a_hs_out: assert property (p_hs_out)
    else $error("hsync output polarity wrong");
  property p_lead;
    hsync_lead_o |-> pll_hsync_o && !$past(pll_hsync_o);
  endproperty
  a_lead: assert property (p_lead)
    else $error("leading edge pulse off edge");
  property p_clamp_ext;
    quiet_ff > 4'h7 && clmp_ff.clamp_external |-> clamp_o == (pins_i.clamp ^ clmp_ff.clamp_active_low);
  endproperty
  a_clamp_ext: assert property (p_clamp_ext)
    else $error("external clamp level wrong");
  property p_coast_pin;
    quiet_ff > 4'h7 && !clmp_ff.coast_from_vsync |-> coast_o == pins_i.coast;
  endproperty
  a_coast_pin: assert property (p_coast_pin)
    else $error("coast does not follow pin");
  property p_vs_out;
    quiet_ff > 4'h7 && mode_ff.avs_override && !mode_ff.avs_select |->
      vsync_o == (pins_i.vsync ^ !mode_ff.vsync_out_keep);
  endproperty
  a_vs_out: assert property (p_vs_out)
    else $error("vsync output invert wrong");
  property p_rd_mode;
    reg_rd_i && reg_addr_i == `SCMC_ADDR_MODE |=> reg_rvalid_o && reg_rdata_o == $past(mode_ff);
  endproperty
  a_rd_mode: assert property (p_rd_mode)
    else $error("mode register readback wrong");
endmodule

bind scmc_top scmc_chk u_chk (.sys_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o, .reg_rvalid_o, .pins_i, .hsync_activity_i, .green_activity_i, .vsync_activity_i,
  .hsync_o, .vsync_o, .pll_hsync_o, .hsync_lead_o, .clamp_o, .coast_o, .active_hsync_source_o,
  .active_vsync_source_o, .hsync_polarity_o);

`default_nettype wire

// ==== bench/scmc_src_model.sv ====
// Graphics source model: periodic hsync plus static sync, clamp and coast levels
`timescale 1ns/100ps
`default_nettype none

module scmc_src_model
  import scmc_pkg::*;
(
  input wire logic sys_clk_i, // Line timing reference
  input wire logic act_low_i, // Hsync pulse low-going
  input wire scmc_pins_type lvl_i, // Levels of the other pins
  output scmc_pins_type pins_o // Pins toward the device
);
  logic [5:0] pos_ff = 6'h00;

  // Line of 40 cycles with a 4-cycle pulse, short enough to be the minority phase
  always @(posedge sys_clk_i)
    pos_ff <= (pos_ff == 6'h27) ? 6'h00 : pos_ff + 6'h01;

  assign pins_o = {(pos_ff < 6'h04) ^ act_low_i, lvl_i[4:0]};
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the sync and clamp mode control
`timescale 1ns/100ps
`default_nettype none
`include "scmc_defs.svh"

module tb_top;
  import scmc_pkg::*;
  logic sys_clk_i;
  logic rst_n_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  scmc_pins_type pins_i;
  scmc_pins_type lvl;
  logic act_low;
  logic hsync_activity_i;
  logic green_activity_i;
  logic vsync_activity_i;
  logic [7:0] clamp_place_i;
  logic [7:0] clamp_dur_i;
  logic hsync_o;
  logic green_sync_o;
  logic vsync_o;
  logic pll_hsync_o;
  logic hsync_lead_o;
  logic clamp_o;
  logic coast_o;
  logic active_hsync_source_o;
  logic active_vsync_source_o;
  logic hsync_polarity_o;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int n_hs;
  int n_pll;
  int n_lead;
  int n_cl;

  scmc_src_model u_src (.sys_clk_i, .act_low_i(act_low), .lvl_i(lvl), .pins_o(pins_i));

  scmc_top u_dut (.sys_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .pins_i, .hsync_activity_i, .green_activity_i, .vsync_activity_i, .clamp_place_i,
    .clamp_dur_i, .hsync_o, .green_sync_o, .vsync_o, .pll_hsync_o, .hsync_lead_o, .clamp_o, .coast_o,
    .active_hsync_source_o, .active_vsync_source_o, .hsync_polarity_o);

  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic finish_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard: far above the roughly nine hundred cycles the sequence needs
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      err_count++;
      finish_test;
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #2;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge sys_clk_i);
    #2;
    reg_wr_i = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    #2;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(posedge sys_clk_i);
    #2;
    reg_rd_i = 1'b0;
    // Valid pulse stands only until the next edge, so look now
    check("rvalid", {7'h00, reg_rvalid_o}, 8'h01);
    check("rdata", reg_rdata_o, exp);
  endtask

  task automatic count40;
    n_hs = 0;
    n_pll = 0;
    n_lead = 0;
    n_cl = 0;
    repeat (40)
    begin
      @(posedge sys_clk_i);
      #1;
      n_hs += hsync_o;
      n_pll += pll_hsync_o;
      n_lead += hsync_lead_o;
      n_cl += clamp_o;
    end
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    lvl = 6'h00;
    act_low = 1'b0;
    hsync_activity_i = 1'b0;
    green_activity_i = 1'b0;
    vsync_activity_i = 1'b0;
    clamp_place_i = 8'h03;
    clamp_dur_i = 8'h05;
    repeat (3) @(posedge sys_clk_i);
    #2;
    rst_n_i = 1'b1;
    rd_reg(`SCMC_ADDR_MODE, `SCMC_RST_MODE);
    rd_reg(`SCMC_ADDR_CLAMP, `SCMC_RST_CLAMP);
    rd_reg(8'h20, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(`SCMC_ADDR_MODE, {1'b1, i[0], 2'b01, i[1], 2'b11, i[2]});
      check("hs src", {7'h00, active_hsync_source_o}, {7'h00, i[1]});
      check("avs", {7'h00, active_vsync_source_o}, {7'h00, i[2]});
      check("hpol", {7'h00, hsync_polarity_o}, {7'h00, i[0]});
      rd_reg(`SCMC_ADDR_MODE, {1'b1, i[0], 2'b01, i[1], 2'b11, i[2]});
    end
    for (int j = 0; j < 16; j++)
    begin
      wr_reg(`SCMC_ADDR_MODE, {4'h4, j[3], 3'h4});
      hsync_activity_i = j[0];
      green_activity_i = j[1];
      vsync_activity_i = j[2];
      @(posedge sys_clk_i);
      #1;
      check("hs src auto", {7'h00, active_hsync_source_o}, {7'h00, (j[0] ^ j[1]) ? j[1] : j[3]});
      check("avs auto", {7'h00, active_vsync_source_o}, {7'h00, !j[2]});
    end
    // Only the pin shows activity, so the pulsing pin is the active source
    #1;
    green_activity_i = 1'b0;
    repeat (200) @(posedge sys_clk_i);
    count40;
    check("hpol auto", {7'h00, hsync_polarity_o}, 8'h01);
    check("hs high", n_hs[7:0], 8'h04);
    check("green idle high pol", {7'h00, green_sync_o}, 8'h00);
    rd_reg(`SCMC_ADDR_STATUS, 8'hB0);
    wr_reg(`SCMC_ADDR_MODE, 8'h24);
    count40;
    check("hs low", n_hs[7:0], 8'h24);
    check("green idle low pol", {7'h00, green_sync_o}, 8'h01);
    act_low = 1'b1;
    repeat (200) @(posedge sys_clk_i);
    wr_reg(`SCMC_ADDR_CLAMP, 8'h00);
    count40;
    check("hpol det", {7'h00, hsync_polarity_o}, 8'h00);
    check("pll norm", n_pll[7:0], 8'h04);
    check("lead", n_lead[7:0], 8'h01);
    check("int clamp", n_cl[7:0], clamp_dur_i);
    wr_reg(`SCMC_ADDR_MODE, 8'hC4);
    repeat (80) @(posedge sys_clk_i);
    count40;
    check("wrong pol clamp", n_cl[7:0], clamp_dur_i);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(`SCMC_ADDR_CLAMP, {1'b1, k[1], 6'h00});
      lvl.clamp = k[0];
      repeat (10) @(posedge sys_clk_i);
      #1;
      check("ext clamp", {7'h00, clamp_o}, {7'h00, k[0] ^ k[1]});
    end
    for (int m = 0; m < 8; m++)
    begin
      wr_reg(`SCMC_ADDR_MODE, {5'h00, m[0], 2'b10});
      wr_reg(`SCMC_ADDR_CLAMP, {2'b01, m[1], 5'h00});
      lvl.vsync = m[2];
      lvl.coast = !m[2];
      repeat (10) @(posedge sys_clk_i);
      #1;
      check("vsync", {7'h00, vsync_o}, {7'h00, m[2] ^ !m[0]});
      check("coast", {7'h00, coast_o}, {7'h00, m[2] ^ !m[1]});
    end
    @(posedge sys_clk_i);
    #2;
    rst_n_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #2;
    rst_n_i = 1'b1;
    rd_reg(`SCMC_ADDR_MODE, `SCMC_RST_MODE);
    finish_test;
  end
endmodule

`default_nettype wire
